// ==== include/cbr_pkg.sv ====
// Purpose: shared constants and types for the card bridge configuration registers
// Assumes: configuration cycles arrive as dword-aligned accesses with byte enables
// Notes: offsets are configuration space byte addresses
package cbr_pkg;
  // configuration space byte offsets
  localparam logic [7:0] CBR_OFF_CAP_HEAD = 8'h14;
  localparam logic [7:0] CBR_OFF_MEM_TIM = 8'h8A;
  localparam logic [7:0] CBR_OFF_DMA_SLV = 8'h90;
  localparam logic [7:0] CBR_OFF_CAP_KIND = 8'hDC;
  localparam logic [7:0] CBR_OFF_CAP_NEXT = 8'hDD;
  // dword indices used by the decoder
  localparam logic [5:0] CBR_DW_CAP_HEAD = 6'h05;
  localparam logic [5:0] CBR_DW_MEM_TIM = 6'h22;
  localparam logic [5:0] CBR_DW_DMA_SLV = 6'h24;
  localparam logic [5:0] CBR_DW_CAP_KIND = 6'h37;
  // read-only values
  localparam logic [7:0] CBR_CAP_HEAD_VAL = 8'hDC;
  localparam logic [7:0] CBR_CAP_KIND_VAL = 8'h01;
  localparam logic [7:0] CBR_CAP_NEXT_VAL = 8'h00;
  // memory timing fields and reset values
  localparam int CBR_HOLD_LSB = 10;
  localparam int CBR_PULSE_LSB = 4;
  localparam int CBR_SETUP_LSB = 0;
  localparam logic [15:0] CBR_MEM_TIM_RST = 16'h0463;
  localparam logic [15:0] CBR_MEM_TIM_MASK = 16'h1DF7;
  // default timing when enhanced timing is off
  localparam logic [2:0] CBR_DEF_HOLD = 3'h1;
  localparam logic [4:0] CBR_DEF_PULSE = 5'h06;
  localparam logic [2:0] CBR_DEF_SETUP = 3'h3;
  // dma slave fields
  localparam logic [31:0] CBR_DMA_RST = 32'h0000_0000;
  localparam int CBR_DMA_EXT_BIT = 3;
  localparam int CBR_DMA_SIZE_LSB = 1;
  localparam int CBR_DMA_EN_BIT = 0;
  localparam logic [1:0] CBR_SIZE_8 = 2'h0;
  localparam logic [1:0] CBR_SIZE_16 = 2'h1;
  localparam int CBR_SOCKETS = 2;

  typedef struct packed {
    logic [2:0] hold;
    logic [4:0] pulse;
    logic [2:0] setup;
  } cbr_mem_tim_t;

  typedef struct packed {
    logic [27:0] base;
    logic ext_addr;
    logic wide16;
    logic decode_en;
  } cbr_dma_cfg_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] dw;
    logic [3:0] be;
    logic [31:0] wdata;
  } cbr_cfg_req_t;
endpackage

// ==== logic/cbr_tim_reg.sv ====
// Purpose: one socket's 16-bit card memory timing register
// Assumes: write strobe and byte enables are already decoded for this socket
// Notes: reserved bits are never stored, so they read zero
`timescale 1ns/1ps
module cbr_tim_reg (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wr,
  input wire logic [1:0] be,
  input wire logic [15:0] wdata,
  input wire logic enh_en,
  output logic [15:0] value_r,
  output cbr_pkg::cbr_mem_tim_t tim_r
);
  import cbr_pkg::*;
  logic [15:0] value_nxt;
  cbr_mem_tim_t tim_nxt;

  always_comb begin
    value_nxt = value_r;
    if (wr) begin
      if (be[0]) value_nxt[7:0] = wdata[7:0];
      if (be[1]) value_nxt[15:8] = wdata[15:8];
    end
    value_nxt = value_nxt & CBR_MEM_TIM_MASK; // R04
    if (enh_en) begin // R06
      tim_nxt.hold = value_r[CBR_HOLD_LSB+:3]; // R01
      tim_nxt.pulse = value_r[CBR_PULSE_LSB+:5]; // R02
      tim_nxt.setup = value_r[CBR_SETUP_LSB+:3]; // R03
    end else begin
      tim_nxt.hold = CBR_DEF_HOLD;
      tim_nxt.pulse = CBR_DEF_PULSE;
      tim_nxt.setup = CBR_DEF_SETUP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      value_r <= CBR_MEM_TIM_RST;
      tim_r <= '{hold: CBR_DEF_HOLD, pulse: CBR_DEF_PULSE, setup: CBR_DEF_SETUP};
    end else if (clk_en) begin
      value_r <= value_nxt;
      tim_r <= tim_nxt;
    end
  end

  AST_TIM_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (value_r & ~CBR_MEM_TIM_MASK) == 16'h0000) // R04
    else $error("timing reserved bits nonzero");
endmodule // cbr_tim_reg

// ==== logic/cbr_cfg_regs.sv ====
// Purpose: card bridge configuration registers reached by configuration cycles
// Assumes: one access per cycle, read data returned the next cycle
// Notes: socket select picks which timing set the memory timing offset reaches
//////////////////////////////////////////////////////////////////////////////
// Contract
// R01: hold time from timing bits 12-10, reset 001
// R02: strobe width from bits 8-4, reset 00110
// R03: setup time from bits 2-0, reset 011
// R04: timing bits 15-13, 9, 3 read zero
// R05: separate timing set per socket
// R06: programmed timing only when enhanced enable set
// R07: dma slave register at 90h, reset zero
// R08: bits 31-4 give dma decode base
// R09: bit 3 extends address and count widths
// R10: bits 2-1 pick 8 or 16 bit
// R11: decode only with channel and dma enable
// R12: pointer at 14h reads 0DCh
// R13: capability id byte reads 01h
// R14: next link byte reads 00h
// R15: writes to read-only bytes complete, no effect
`timescale 1ns/1ps
module cbr_cfg_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input cbr_pkg::cbr_cfg_req_t req,
  input wire logic sock_sel,
  input wire logic enh_timing_en,
  input wire logic misc_dma_en,
  output logic [31:0] rdata_r,
  output logic ack_r,
  output cbr_pkg::cbr_mem_tim_t tim0_r,
  output cbr_pkg::cbr_mem_tim_t tim1_r,
  output cbr_pkg::cbr_dma_cfg_t dma_r
);
  import cbr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  logic [31:0] dma_reg_r, dma_reg_nxt;
  logic [31:0] rdata_nxt;
  cbr_dma_cfg_t dma_nxt;
  logic [15:0] tim_val [CBR_SOCKETS];
  cbr_mem_tim_t tim_out [CBR_SOCKETS];
  logic tim_wr [CBR_SOCKETS];
  logic [15:0] tim_sel;

  // timing occupies the upper half of dword 22h (bytes 8Ah-8Bh)
  genvar g;
  generate
    for (g = 0; g < CBR_SOCKETS; g++) begin : g_sock
      assign tim_wr[g] = req.wr && req.dw == CBR_DW_MEM_TIM &&
                         (sock_sel == 1'(g)); // R05
      cbr_tim_reg u_tim (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .wr(tim_wr[g]),
        .be(req.be[3:2]),
        .wdata(req.wdata[31:16]),
        .enh_en(enh_timing_en),
        .value_r(tim_val[g]),
        .tim_r(tim_out[g])
      );
    end
  endgenerate
  assign tim0_r = tim_out[0];
  assign tim1_r = tim_out[1];
  assign tim_sel = sock_sel ? tim_val[1] : tim_val[0];

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    dma_reg_nxt = dma_reg_r;
    if (req.wr && req.dw == CBR_DW_DMA_SLV) begin // R07
      for (int i = 0; i < 4; i++) begin
        if (req.be[i]) dma_reg_nxt[i*8+:8] = req.wdata[i*8+:8];
      end
    end
    dma_nxt.base = dma_reg_r[31:4]; // R08
    dma_nxt.ext_addr = dma_reg_r[CBR_DMA_EXT_BIT]; // R09
    // 32-bit and reserved codes are illegal to program; only 16-bit widens
    dma_nxt.wide16 = dma_reg_r[CBR_DMA_SIZE_LSB+:2] == CBR_SIZE_16; // R10
    dma_nxt.decode_en = dma_reg_r[CBR_DMA_EN_BIT] && misc_dma_en; // R11
  end

  // writes to read-only bytes are acked but change nothing
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (req.rd) begin
      unique case (req.dw)
        CBR_DW_CAP_HEAD: rdata_nxt[7:0] = CBR_CAP_HEAD_VAL; // R12
        CBR_DW_MEM_TIM: rdata_nxt[31:16] = tim_sel; // R05
        CBR_DW_DMA_SLV: rdata_nxt = dma_reg_r;
        CBR_DW_CAP_KIND: rdata_nxt[15:0] = {CBR_CAP_NEXT_VAL, CBR_CAP_KIND_VAL}; // R13 R14
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dma_reg_r <= CBR_DMA_RST;
      dma_r <= '0;
      rdata_r <= 32'h0000_0000;
      ack_r <= 1'b0;
    end else if (clk_en) begin
      dma_reg_r <= dma_reg_nxt;
      dma_r <= dma_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= req.rd | req.wr; // R15
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  AST_CAP_HEAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && req.rd && req.dw == CBR_DW_CAP_HEAD |=> rdata_r == 32'h0000_00DC) // R12
    else $error("capability pointer wrong");
  AST_CAP_KIND: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && req.rd && req.dw == CBR_DW_CAP_KIND |=> rdata_r == 32'h0000_0001) // R13 R14
    else $error("capability id or link wrong");
  AST_DMA_WR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && req.wr && req.dw == CBR_DW_DMA_SLV && req.be == 4'hF
    |=> dma_reg_r == $past(req.wdata)) // R07
    else $error("dma slave write lost");
  AST_DMA_BASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> dma_r.base == $past(dma_reg_r[31:4])) // R08
    else $error("dma base wrong");
  AST_DMA_EXT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> dma_r.ext_addr == $past(dma_reg_r[3])) // R09
    else $error("extended addressing wrong");
  AST_DMA_DEC: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !misc_dma_en |=> !dma_r.decode_en) // R11
    else $error("decode without dma enable");
  AST_DMA_W16: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && dma_reg_r[2:1] == 2'h0 |=> !dma_r.wide16) // R10
    else $error("8-bit size decoded as 16");
  AST_TIM_DEF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !enh_timing_en |=> tim0_r.pulse == 5'h06 && tim0_r.setup == 3'h3) // R06
    else $error("default timing not applied");
  AST_TIM_PROG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && enh_timing_en |=> tim1_r.hold == $past(tim_val[1][12:10])) // R01
    else $error("programmed hold not applied");
  AST_ACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && req.wr && req.dw == CBR_DW_CAP_HEAD |=> ack_r ##0 $stable(tim_val[0])) // R15
    else $error("read-only write not completed");
  COV_DMA_ON: cover property (@(posedge sys_clk) disable iff (!rst_n) dma_r.decode_en);
  COV_TIM_WR1: cover property (@(posedge sys_clk) disable iff (!rst_n) tim_wr[1] && clk_en);
  COV_CAP_RD: cover property (@(posedge sys_clk) disable iff (!rst_n)
    req.rd && req.dw == CBR_DW_CAP_KIND && clk_en);
endmodule // cbr_cfg_regs

// ==== tb/cbr_host_bfm.sv ====
// Purpose: host bridge model issuing configuration cycles
// Assumes: requests change at the falling edge
// Notes: a missing ack yields unknown data so compares fail
`timescale 1ns/1ps
module cbr_host_bfm (
  input wire logic sys_clk,
  input wire logic ack_r,
  input wire logic [31:0] rdata_r,
  output cbr_pkg::cbr_cfg_req_t req
);
  import cbr_pkg::*;
  initial req = '0;
  //////////////////////////////////////////////////////////////////////////////
  // one-cycle request, answer sampled one cycle later
  task automatic xfer(input logic w, input logic [5:0] dw, input logic [31:0] wd,
      output logic [31:0] rd);
    @(negedge sys_clk);
    req = '{rd: !w, wr: w, dw: dw, be: 4'hF, wdata: wd};
    @(negedge sys_clk);
    req = '0;
    rd = (ack_r === 1'b1) ? rdata_r : 32'hXXXX_XXXX;
  endtask
endmodule // cbr_host_bfm

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the card bridge configuration registers
// Assumes: clk_en held high except for the ignored write near the end of the run
// Notes: outputs checked one cycle after the write that feeds them
`timescale 1ns/1ps
module testbench;
  import cbr_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sock_sel = 1'b0;
  logic enh_timing_en = 1'b1;
  logic misc_dma_en = 1'b0;
  logic clk_en = 1'b1;
  cbr_cfg_req_t req;
  logic [31:0] rdata_r;
  logic ack_r;
  cbr_mem_tim_t tim0_r, tim1_r;
  cbr_dma_cfg_t dma_r;
  int errors = 0, n_checks = 0, cyc = 0;
  always #20 sys_clk = ~sys_clk;
  cbr_cfg_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
    .sock_sel(sock_sel), .enh_timing_en(enh_timing_en), .misc_dma_en(misc_dma_en),
    .rdata_r(rdata_r), .ack_r(ack_r), .tim0_r(tim0_r), .tim1_r(tim1_r), .dma_r(dma_r));
  cbr_host_bfm host (.sys_clk(sys_clk), .ack_r(ack_r), .rdata_r(rdata_r), .req(req));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] dw, input logic [31:0] d);
    logic [31:0] x;
    host.xfer(1'b1, dw, d, x);
    // a write must be acknowledged and carry no read data
    chk(x, 32'h0);
  endtask
  task automatic rd(input logic [5:0] dw, input logic [31:0] e);
    logic [31:0] x;
    host.xfer(1'b0, dw, 32'h0, x);
    chk(x, e);
  endtask
  task automatic tick();
    @(negedge sys_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // the run needs about 50 cycles; the 400-cycle limit leaves a wide margin
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 400) begin
      errors++;
      $display("BAD t=%0t timeout", $time);
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] junk;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    chk(32'(tim0_r), 32'h0000_0133);
    chk(32'(dma_r), 32'h0);
    rd(CBR_DW_CAP_HEAD, 32'h0000_00DC);
    rd(CBR_DW_CAP_KIND, 32'h0000_0001);
    rd(CBR_DW_MEM_TIM, 32'h0463_0000);
    rd(CBR_DW_DMA_SLV, 32'h0);
    rd(6'h3F, 32'h0);
    wr(CBR_DW_CAP_HEAD, 32'hFFFF_FFFF);
    wr(CBR_DW_CAP_KIND, 32'hFFFF_FFFF);
    rd(CBR_DW_CAP_HEAD, 32'h0000_00DC);
    rd(CBR_DW_CAP_KIND, 32'h0000_0001);
    wr(CBR_DW_MEM_TIM, 32'hFFFF_0000);
    rd(CBR_DW_MEM_TIM, 32'h1DF7_0000);
    chk(32'(tim0_r), 32'h0000_07FF);
    chk(32'(tim1_r), 32'h0000_0133);
    sock_sel = 1'b1;
    rd(CBR_DW_MEM_TIM, 32'h0463_0000);
    sock_sel = 1'b0;
    enh_timing_en = 1'b0;
    tick();
    chk(32'(tim0_r), 32'h0000_0133);
    enh_timing_en = 1'b1;
    tick();
    chk(32'(tim0_r), 32'h0000_07FF);
    wr(CBR_DW_DMA_SLV, 32'h1234_567B);
    rd(CBR_DW_DMA_SLV, 32'h1234_567B);
    chk(32'(dma_r), 32'h091A_2B3E);
    misc_dma_en = 1'b1;
    tick();
    chk(32'(dma_r), 32'h091A_2B3F);
    // only the 8-bit and 16-bit size codes are ever programmed
    for (int s = 0; s < 2; s++) begin
      wr(CBR_DW_DMA_SLV, {29'h0, s[1:0], 1'b1});
      tick();
      chk(32'(dma_r), {30'h0, s[0], 1'b1});
    end
    wr(CBR_DW_DMA_SLV, 32'h0000_0008);
    tick();
    chk(32'(dma_r), 32'h0000_0004);
    wr(CBR_DW_DMA_SLV, 32'h0);
    tick();
    chk(32'(dma_r), 32'h0);
    // with the enable low a write must be ignored and not acknowledged
    clk_en = 1'b0;
    host.xfer(1'b1, CBR_DW_DMA_SLV, 32'hFFFF_FFFF, junk);
    chk(junk, 32'hXXXX_XXXX);
    clk_en = 1'b1;
    rd(CBR_DW_DMA_SLV, 32'h0);
    wrap_up();
  end
endmodule // testbench
